// *** hdl/gpiop_pkg.sv ***
/*
 gpiop_pkg: register offsets, reset values, field codes and decode bases for the sixteen-pin port.
 assumes: one port instance per base address, registers on the AHB-Lite system bus with 32-bit data.
*/
package gpiop_pkg;
    // ===========================================================
    // sizes
    localparam int          PINS       = 16;
    localparam int          AF_COUNT   = 16;
    localparam int          AF_W       = 4;
    localparam int          PORTS      = 5;
    // ===========================================================
    // register byte offsets
    localparam logic [5:0]  OFS_MODE   = 6'h00;
    localparam logic [5:0]  OFS_OTYPE  = 6'h04;
    localparam logic [5:0]  OFS_SLEW   = 6'h08;
    localparam logic [5:0]  OFS_PULL   = 6'h0C;
    localparam logic [5:0]  OFS_ISTAT  = 6'h10;
    localparam logic [5:0]  OFS_OCTL   = 6'h14;
    localparam logic [5:0]  OFS_SETCLR = 6'h18;
    localparam logic [5:0]  OFS_FREEZE = 6'h1C;
    localparam logic [5:0]  OFS_AFSEL0 = 6'h20;
    localparam logic [5:0]  OFS_AFSEL1 = 6'h24;
    localparam logic [5:0]  OFS_CLR    = 6'h28;
    localparam logic [5:0]  OFS_TOGGLE = 6'h2C;
    // ===========================================================
    // reset values
    localparam logic [31:0] MODE_RST_A = 32'h2800_0000;
    localparam logic [31:0] MODE_RST   = 32'h0000_0000;
    localparam logic [31:0] SLEW_RST_A = 32'h0C00_0000;
    localparam logic [31:0] PULL_RST_A = 32'h2400_0000;
    localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
    // ===========================================================
    // field codes
    localparam logic [1:0]  MODE_IN    = 2'h0;
    localparam logic [1:0]  MODE_OUT   = 2'h1;
    localparam logic [1:0]  MODE_AF    = 2'h2;
    localparam logic [1:0]  MODE_ANA   = 2'h3;
    localparam logic [1:0]  PULL_UP    = 2'h1;
    localparam logic [1:0]  PULL_DN    = 2'h2;
    localparam int          FRZ_KEY    = 16;
    localparam logic [1:0]  HTRANS_NSQ = 2'h2;
    localparam logic [2:0]  HSIZE_HALF = 3'h1;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    // ===========================================================
    // decode bases, port a first
    localparam logic [31:0] BASES [PORTS] = '{32'h4800_0000, 32'h4800_0400, 32'h4800_0800,
                                              32'h4800_0C00, 32'h4800_1400};
    localparam int          BASE_LSB   = 10;

    typedef enum logic [1:0] {GPIOP_FRZ_IDLE, GPIOP_FRZ_ONE, GPIOP_FRZ_ZERO} gpiop_frz_t;
endpackage

// *** hdl/gpiop_port.sv ***
/*
 gpiop_port: one sixteen-pin general-purpose port with AHB-Lite register slave and pad control.
 assumes: pad levels arrive asynchronously; pad drivers, pulls and Schmitt enables sit outside;
 peripherals present sixteen alternate-function drive candidates per pin.
*/
// Functional notes
// - after reset pins are floating inputs, no pulls, alternate functions off, except debug pins
// - port a pin 14 resets to alternate function pull-down, pin 13 to pull-up
// - in input mode the pad level is sampled into input status every clock
// - general output mode drives the pin from the output control register
// - set, clear and toggle writes change exactly the written-one bits atomically
// - zero bits in set, clear or toggle writes leave output control unchanged
// - mode 10 connects the pin to one of sixteen alternate functions by select field
// - an enabled additional function overrides port configuration; normal behaviour when disabled
// - input mode: Schmitt on, chosen pull allowed, output driver off
// - open-drain: drive low for 0, release pad for 1
// - push-pull: drive low for 0, high for 1
// - output and alternate modes read back written output control and actual pad level
// - analog mode: pulls, driver and Schmitt off; input status reads 0
// - alternate mode: peripheral drives push-pull or open-drain; pad still sampled every clock
// - after the freeze sequence a pin's configuration ignores writes until reset
// - a toggle write inverts the output within one clock
// - the five ports decode at their five fixed base addresses
// - mode register: two bits per pin, 00 input, 01 output, 10 alternate, 11 analog
// - mode register resets to 0x2800_0000 on port a and zero elsewhere
// - mode register takes byte, half-word and word writes on addressed lanes only
// - output-type bit clear selects push-pull (reset), set selects open-drain
`timescale 1ns/1ns
module gpiop_port
    import gpiop_pkg::*;
#(
    parameter int PORT_IDX = 0
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // ahb-lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    // pads
    input  wire logic [gpiop_pkg::PINS-1:0]    pad_in,
    output logic      [gpiop_pkg::PINS-1:0]    pad_out,
    output logic      [gpiop_pkg::PINS-1:0]    pad_oe,
    output logic      [gpiop_pkg::PINS-1:0]    pull_up_en,
    output logic      [gpiop_pkg::PINS-1:0]    pull_down_en,
    output logic      [gpiop_pkg::PINS-1:0]    schmitt_en,
    output logic      [2*gpiop_pkg::PINS-1:0]  slew_sel,
    // alternate functions, pin i candidate k at index 16*i+k
    input  wire logic [gpiop_pkg::PINS*gpiop_pkg::AF_COUNT-1:0] alt_drive,
    input  wire logic [gpiop_pkg::PINS*gpiop_pkg::AF_COUNT-1:0] alt_drive_oe,
    output logic      [gpiop_pkg::PINS-1:0]    alt_pad_level,
    // additional functions
    input  wire logic [gpiop_pkg::PINS-1:0]    extra_fn_en,
    input  wire logic [gpiop_pkg::PINS-1:0]    extra_fn_out,
    input  wire logic [gpiop_pkg::PINS-1:0]    extra_fn_oe,
    input  wire logic [gpiop_pkg::PINS-1:0]    extra_fn_analog
);
    import gpiop_pkg::*;

    // ===========================================================
    // state
    typedef struct packed {
        logic [31:0]     mode_r;
        logic [15:0]     otype_r;
        logic [31:0]     slew_r;
        logic [31:0]     pull_r;
        logic [31:0]     afsel0_r;
        logic [31:0]     afsel1_r;
        logic [15:0]     octl_r;
        logic [15:0]     istat_r;
        logic [15:0]     pad_meta_r;
        logic [15:0]     pad_sync_r;
        logic [15:0]     frozen_r;
        logic            frz_done_r;
        gpiop_frz_t      frz_st_r;
        logic [15:0]     frz_mask_r;
        logic            dph_wr_r;
        logic [5:0]      dph_ofs_r;
        logic [3:0]      dph_lane_r;
        logic [31:0]     rdata_r;
    } gpiop_state_t;

    localparam bit IS_PORT_A = (PORT_IDX == 0);

    localparam gpiop_state_t RST_STATE = '{
        mode_r:     IS_PORT_A ? MODE_RST_A : MODE_RST,
        slew_r:     IS_PORT_A ? SLEW_RST_A : ZERO_RST,
        pull_r:     IS_PORT_A ? PULL_RST_A : ZERO_RST,
        otype_r:    16'h0000,
        frz_st_r:   GPIOP_FRZ_IDLE,
        default:    '0
    };

    gpiop_state_t st_r;
    gpiop_state_t st_nxt;

    logic [31:0]  wmask;
    logic [31:0]  cfg_keep2;
    logic [31:0]  af_keep0;
    logic [31:0]  af_keep1;
    logic [31:0]  wd;
    logic         addr_hit;
    logic [3:0]   lanes;
    logic [63:0]  afsel_all;
    logic [15:0]  pin_analog;

    // ===========================================================
    // address phase decode
    localparam logic [31:0] MY_BASE = BASES[PORT_IDX];

    assign addr_hit = hsel && hready && htrans[1] &&
                      (haddr[31:BASE_LSB] == MY_BASE[31:BASE_LSB]);

    always_comb begin
        unique case (hsize)
            HSIZE_WORD: lanes = 4'hF;
            HSIZE_HALF: lanes = haddr[1] ? 4'hC : 4'h3;
            default:    lanes = 4'h1 << haddr[1:0];
        endcase
    end

    // ===========================================================
    // pad behaviour, one slice per pin
    assign afsel_all = {st_r.afsel1_r, st_r.afsel0_r};

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            logic [1:0]  mode;
            logic [3:0]  sel;
            logic        drv;
            logic        drv_oe;
            assign mode = st_r.mode_r[2*gi +: 2];
            assign sel  = afsel_all[AF_W*gi +: AF_W];
            assign pin_analog[gi] = (mode == MODE_ANA);

            always_comb begin
                drv    = st_r.octl_r[gi];
                drv_oe = 1'b1;
                if (mode == MODE_AF) begin
                    drv    = alt_drive[AF_COUNT*gi + sel];
                    drv_oe = alt_drive_oe[AF_COUNT*gi + sel];
                end
                pad_out[gi]      = 1'b0;
                pad_oe[gi]       = 1'b0;
                pull_up_en[gi]   = 1'b0;
                pull_down_en[gi] = 1'b0;
                schmitt_en[gi]   = 1'b0;
                if (extra_fn_en[gi]) begin
                    // pin type comes from the owning function, not the port registers
                    pad_out[gi]    = extra_fn_out[gi];
                    pad_oe[gi]     = extra_fn_oe[gi];
                    schmitt_en[gi] = !extra_fn_analog[gi];
                end else if (mode != MODE_ANA) begin
                    schmitt_en[gi]   = 1'b1;
                    pull_up_en[gi]   = (st_r.pull_r[2*gi +: 2] == PULL_UP);
                    pull_down_en[gi] = (st_r.pull_r[2*gi +: 2] == PULL_DN);
                    if (mode != MODE_IN && drv_oe) begin
                        if (st_r.otype_r[gi]) begin
                            pad_oe[gi] = !drv;
                        end else begin
                            pad_oe[gi]  = 1'b1;
                            pad_out[gi] = drv;
                        end
                    end
                end
            end
        end
    endgenerate

    assign slew_sel      = st_r.slew_r;
    assign alt_pad_level = st_r.pad_sync_r & ~pin_analog;

    // ===========================================================
    // bus answer: zero wait, always okay; unmapped reads give zero
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.rdata_r;

    // ===========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        wd     = hwdata;
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{st_r.dph_lane_r[b]}};
        end
        for (int p = 0; p < PINS; p++) begin
            cfg_keep2[2*p +: 2] = {2{st_r.frozen_r[p]}};
        end
        for (int p = 0; p < PINS/2; p++) begin
            af_keep0[AF_W*p +: AF_W] = {AF_W{st_r.frozen_r[p]}};
            af_keep1[AF_W*p +: AF_W] = {AF_W{st_r.frozen_r[p + PINS/2]}};
        end

        // pad synchroniser, second stage feeds status
        st_nxt.pad_meta_r = pad_in;
        st_nxt.pad_sync_r = st_r.pad_meta_r;
        st_nxt.istat_r    = st_r.pad_sync_r & ~pin_analog;

        if (st_r.dph_wr_r) begin
            unique case (st_r.dph_ofs_r)
                OFS_MODE: begin
                    st_nxt.mode_r = (st_r.mode_r & ~(wmask & ~cfg_keep2))
                                  | (wd & wmask & ~cfg_keep2);
                end
                OFS_OTYPE: begin
                    st_nxt.otype_r = (st_r.otype_r & ~(wmask[15:0] & ~st_r.frozen_r))
                                   | (wd[15:0] & wmask[15:0] & ~st_r.frozen_r);
                end
                OFS_SLEW: begin
                    st_nxt.slew_r = (st_r.slew_r & ~(wmask & ~cfg_keep2))
                                  | (wd & wmask & ~cfg_keep2);
                end
                OFS_PULL: begin
                    st_nxt.pull_r = (st_r.pull_r & ~(wmask & ~cfg_keep2))
                                  | (wd & wmask & ~cfg_keep2);
                end
                OFS_AFSEL0: begin
                    st_nxt.afsel0_r = (st_r.afsel0_r & ~(wmask & ~af_keep0))
                                    | (wd & wmask & ~af_keep0);
                end
                OFS_AFSEL1: begin
                    st_nxt.afsel1_r = (st_r.afsel1_r & ~(wmask & ~af_keep1))
                                    | (wd & wmask & ~af_keep1);
                end
                OFS_OCTL: begin
                    st_nxt.octl_r = (st_r.octl_r & ~wmask[15:0]) | (wd[15:0] & wmask[15:0]);
                end
                OFS_SETCLR: begin
                    // clear first so a set of the same bit wins
                    st_nxt.octl_r = (st_r.octl_r & ~(wd[31:16] & wmask[31:16]))
                                  | (wd[15:0] & wmask[15:0]);
                end
                OFS_CLR: begin
                    st_nxt.octl_r = st_r.octl_r & ~(wd[15:0] & wmask[15:0]);
                end
                OFS_TOGGLE: begin
                    st_nxt.octl_r = st_r.octl_r ^ (wd[15:0] & wmask[15:0]);
                end
                OFS_FREEZE: begin
                    // key must be 1,0,1 with an unchanged mask; word writes only
                    if (!st_r.frz_done_r && st_r.dph_lane_r == 4'hF) begin
                        unique case (st_r.frz_st_r)
                            GPIOP_FRZ_IDLE: begin
                                if (wd[FRZ_KEY]) begin
                                    st_nxt.frz_st_r   = GPIOP_FRZ_ONE;
                                    st_nxt.frz_mask_r = wd[15:0];
                                end
                            end
                            GPIOP_FRZ_ONE: begin
                                st_nxt.frz_st_r = (!wd[FRZ_KEY] && wd[15:0] == st_r.frz_mask_r)
                                                ? GPIOP_FRZ_ZERO : GPIOP_FRZ_IDLE;
                            end
                            GPIOP_FRZ_ZERO: begin
                                st_nxt.frz_st_r = GPIOP_FRZ_IDLE;
                                if (wd[FRZ_KEY] && wd[15:0] == st_r.frz_mask_r) begin
                                    st_nxt.frozen_r   = st_r.frozen_r | st_r.frz_mask_r;
                                    st_nxt.frz_done_r = 1'b1;
                                end
                            end
                            default: st_nxt.frz_st_r = GPIOP_FRZ_IDLE;
                        endcase
                    end
                end
                default: ;
            endcase
        end

        // address phase capture
        // offsets past the register block are refused, not aliased onto the low registers
        st_nxt.dph_wr_r   = addr_hit && hwrite && haddr[BASE_LSB-1:6] == '0;
        st_nxt.dph_ofs_r  = {haddr[5:2], 2'b00};
        st_nxt.dph_lane_r = lanes;

        // read data built from the post-write values so a read right after a write sees it
        st_nxt.rdata_r = '0;
        if (addr_hit && !hwrite && haddr[BASE_LSB-1:6] == '0) begin
            unique case ({haddr[5:2], 2'b00})
                OFS_MODE:   st_nxt.rdata_r = st_nxt.mode_r;
                OFS_OTYPE:  st_nxt.rdata_r = {16'h0000, st_nxt.otype_r};
                OFS_SLEW:   st_nxt.rdata_r = st_nxt.slew_r;
                OFS_PULL:   st_nxt.rdata_r = st_nxt.pull_r;
                OFS_ISTAT:  st_nxt.rdata_r = {16'h0000, st_r.istat_r};
                OFS_OCTL:   st_nxt.rdata_r = {16'h0000, st_nxt.octl_r};
                OFS_FREEZE: st_nxt.rdata_r = {15'h0000, st_nxt.frz_done_r, st_nxt.frozen_r};
                OFS_AFSEL0: st_nxt.rdata_r = st_nxt.afsel0_r;
                OFS_AFSEL1: st_nxt.rdata_r = st_nxt.afsel1_r;
                default:    st_nxt.rdata_r = '0;
            endcase
        end
    end

    // ===========================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// *** bench/gpiop_sva.sv ***
/*
 gpiop_sva: port-level checks for gpiop_port.
 assumes: bound into gpiop_port, one clock domain, async reset active high.
*/
`timescale 1ns/1ns
module gpiop_sva
    import gpiop_pkg::*;
#(
    parameter int PORT_IDX = 0
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // pads and overrides
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] pull_up_en,
    input wire logic [15:0] pull_down_en,
    input wire logic [15:0] schmitt_en,
    input wire logic [15:0] extra_fn_en,
    input wire logic [15:0] extra_fn_out,
    input wire logic [15:0] extra_fn_oe,
    input wire logic [15:0] extra_fn_analog
);
    // ==================================================
    // properties
    localparam logic [15:0] UP_RST = (PORT_IDX == 0) ? 16'h2000 : 16'h0000;
    localparam logic [15:0] DN_RST = (PORT_IDX == 0) ? 16'h4000 : 16'h0000;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence no_read;
        !(hsel && hready && htrans[1] && !hwrite);
    endsequence
    sequence released;
        $fell(rst) && extra_fn_en == 16'h0000;
    endsequence
    reset_state_a: assert property (
        released |-> pull_up_en == UP_RST && pull_down_en == DN_RST && schmitt_en == 16'hFFFF
        && (pad_oe & 16'h9FFF) == 16'h0000) else $error("pins not in reset state");
    idle_rdata_a: assert property (no_read |=> hrdata == 32'h0000_0000) else $error("read data without read");
    zero_wait_a: assert property (hreadyout && !hresp) else $error("bus wait or error");
    pull_excl_a: assert property ((pull_up_en & pull_down_en) == 16'h0000) else $error("both pulls on");
    analog_quiet_a: assert property (
        (~schmitt_en & ~extra_fn_en & (pull_up_en | pull_down_en | pad_oe)) == 16'h0000)
        else $error("analog pin not quiet");
    extra_drive_a: assert property (
        ((pad_oe ^ extra_fn_oe) & extra_fn_en) == 16'h0000
        && ((pad_out ^ extra_fn_out) & extra_fn_en & extra_fn_oe) == 16'h0000) else $error("override drive wrong");
    extra_pull_a: assert property (((pull_up_en | pull_down_en) & extra_fn_en) == 16'h0000)
        else $error("override pull on");
    extra_trig_a: assert property (((schmitt_en ^ ~extra_fn_analog) & extra_fn_en) == 16'h0000)
        else $error("override schmitt wrong");
endmodule

bind gpiop_port gpiop_sva #(.PORT_IDX(PORT_IDX)) i_sva (.clk, .rst, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .pad_out, .pad_oe, .pull_up_en, .pull_down_en, .schmitt_en, .extra_fn_en,
    .extra_fn_out, .extra_fn_oe, .extra_fn_analog);

// *** bench/gpiop_pad_model.sv ***
/*
 gpiop_pad_model: pad wires with an outside driver and weak pulls.
 assumes: outside driver enabled only on pins the port does not drive.
*/
`timescale 1ns/1ns
module gpiop_pad_model (
    // clock
    input  wire logic        clk,
    // port side
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe,
    input  wire logic [15:0] pull_up_en,
    input  wire logic [15:0] pull_down_en,
    // outside driver
    input  wire logic [15:0] ext_val,
    input  wire logic [15:0] ext_oe,
    output logic      [15:0] pad_in
);
    // ==================================================
    // floating pads wander so a stale level is never trusted
    logic [15:0] float_r = 16'h0000;
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_oe[i] ? ext_val[i] :
                        pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : float_r[i];
        end
    end
endmodule

// *** bench/tb_general_purpose_io_port.sv ***
/*
 tb_general_purpose_io_port: self-checking bench for gpiop_port as port a.
 assumes: gpiop_pad_model and gpiop_sva compiled alongside.
*/
`timescale 1ns/1ns
module tb_general_purpose_io_port;
    import gpiop_pkg::*;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, m_mode, m_pull, m_af0, m_af1, slew;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [15:0] pad_in, pad_out, pad_oe, pu, pd, st, ext_val = 0, ext_oe = 0, m_otype, m_octl, m_frz;
    logic [15:0] xen = 0, xout = 0, xoe = 0, xana = 0, apl;
    logic [255:0] alt_drive = 0, alt_oe = 0;
    logic [5:0] ops [4] = '{OFS_OCTL, OFS_SETCLR, OFS_CLR, OFS_TOGGLE};
    integer seed = 32'hbcce;
    int n_errors = 0, checked = 0, cycles = 0;
    // ==================================================
    // design and pads
    gpiop_port #(.PORT_IDX(0)) i_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout(), .hresp(), .pad_in, .pad_out, .pad_oe, .pull_up_en(pu), .pull_down_en(pd),
        .schmitt_en(st), .slew_sel(slew), .alt_drive, .alt_drive_oe(alt_oe), .alt_pad_level(apl),
        .extra_fn_en(xen), .extra_fn_out(xout), .extra_fn_oe(xoe), .extra_fn_analog(xana));
    gpiop_pad_model i_pads (.clk, .pad_out, .pad_oe, .pull_up_en(pu), .pull_down_en(pd), .ext_val, .ext_oe,
        .pad_in);
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("Error t=%0t run too long", $time);
            final_report();
        end
    end
    // ==================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] d);
        @(negedge clk);
        hsel = 1'b1;
        htrans = HTRANS_NSQ;
        haddr = a;
        hwrite = w;
        hsize = sz;
        @(negedge clk);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = d;
        r = hrdata;
    endtask
    task automatic rd(input logic [5:0] o, input logic [31:0] e);
        bus(BASES[0] + 32'(o), 1'b0, HSIZE_WORD, 32'h0000_0000);
        check(r, e);
    endtask
    // bench model follows mode, pull, output-type, select and output writes; frozen pins keep their mode, pull and type fields
    task automatic wr(input logic [5:0] o, input logic [31:0] d, input logic [2:0] sz = HSIZE_WORD);
        logic [31:0] lm, k2;
        bus(BASES[0] + 32'(o), 1'b1, sz, d);
        lm = sz == 3'h0 ? 32'h0000_00FF << (8 * o[1:0]) : sz == HSIZE_HALF ? 32'h0000_FFFF << (8 * o[1:0]) : '1;
        for (int i = 0; i < 16; i++) k2[2*i+:2] = lm[2*i+:2] & ~{2{m_frz[i]}};
        case (o & 6'h3C)
            OFS_MODE: m_mode = (m_mode & ~k2) | (d & k2);
            OFS_PULL: m_pull = (m_pull & ~k2) | (d & k2);
            OFS_OTYPE: m_otype = (m_otype & m_frz) | (d[15:0] & ~m_frz);
            OFS_AFSEL0: m_af0 = d;
            OFS_AFSEL1: m_af1 = d;
            OFS_OCTL: m_octl = d[15:0];
            OFS_SETCLR: m_octl = (m_octl & ~d[31:16]) | d[15:0];
            OFS_CLR: m_octl = m_octl & ~d[15:0];
            OFS_TOGGLE: m_octl = m_octl ^ d[15:0];
            default: ;
        endcase
        @(negedge clk);
    endtask
    task automatic pads();
        logic [15:0] oe, ou;
        int s;
        for (int i = 0; i < 16; i++) begin
            s = 16 * i + int'(i < 8 ? m_af0[4*i+:4] : m_af1[4*(i-8)+:4]);
            case (m_mode[2*i+:2])
                MODE_OUT: {oe[i], ou[i]} = m_otype[i] ? {~m_octl[i], 1'b0} : {1'b1, m_octl[i]};
                MODE_AF: {oe[i], ou[i]} = m_otype[i] ? {alt_oe[s] & ~alt_drive[s], 1'b0} : {alt_oe[s], alt_drive[s]};
                default: {oe[i], ou[i]} = 2'b00;
            endcase
        end
        check(pad_oe, oe);
        check(pad_out & pad_oe, ou & oe);
    endtask
    task automatic mreset();
        {m_mode, m_pull, m_af0, m_af1} = {MODE_RST_A, PULL_RST_A, ZERO_RST, ZERO_RST};
        {m_otype, m_octl, m_frz} = 48'h0;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==================================================
    // scenarios
    initial begin
        mreset();
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(OFS_MODE, MODE_RST_A);
        rd(OFS_PULL, PULL_RST_A);
        rd(OFS_OTYPE, ZERO_RST);
        check(slew, SLEW_RST_A);
        pads();
        $display("test reset done");
        for (int a = 0; a < 4; a++) begin
            wr(6'(a), $random(seed), 3'h0);
            rd(OFS_MODE, m_mode);
            wr(6'(a & 2), $random(seed), HSIZE_HALF);
            rd(OFS_MODE, m_mode);
        end
        $display("test lanes done");
        wr(OFS_MODE, 32'h2855_FF00);
        wr(OFS_OTYPE, $random(seed) & 32'h0000_0F00);
        for (int n = 0; n < 24; n++) begin
            wr(ops[n % 4], $random(seed));
            pads();
            rd(OFS_OCTL, {16'h0000, m_octl});
        end
        $display("test output done");
        wr(OFS_OTYPE, 32'h0000_0000);
        wr(OFS_PULL, 32'h2400_0909);
        check({pu, pd}, 32'h2001_4002);
        ext_oe = 16'h90FF;
        for (int n = 0; n < 4; n++) begin
            ext_val = 16'($random(seed));
            repeat (4) @(negedge clk);
            bus(BASES[0] + 32'(OFS_ISTAT), 1'b0, HSIZE_WORD, 32'h0000_0000);
            check(r & 32'h0000_9FFF, (ext_val & 16'h900F) | (m_octl & 16'h0F00));
            check(apl & 16'h9FFF, (ext_val & 16'h900F) | (m_octl & 16'h0F00));
        end
        check(st & 16'h00F0, 32'h0000_0000);
        $display("test input done");
        wr(OFS_MODE, 32'h28AA_FFAA);
        wr(OFS_OTYPE, 32'h0000_0A00);
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 8; j++) {alt_drive[32*j+:32], alt_oe[32*j+:32]} = {$random(seed), $random(seed)};
            wr(OFS_AFSEL1, {16'h0000, 4'(k + 3), 4'(k + 2), 4'(k + 1), 4'(k)});
            wr(OFS_AFSEL0, $random(seed));
            pads();
        end
        rd(OFS_AFSEL1, m_af1);
        rd(OFS_AFSEL0, m_af0);
        $display("test alternate done");
        {xen, xana, xoe, xout} = {16'h0300, 16'h0200, 16'h0100, 16'(($random(seed)))};
        @(negedge clk);
        check({pad_oe[8], pad_out[8], st[9]}, {1'b1, xout[8], 1'b0});
        xen = 16'h0000;
        @(negedge clk);
        pads();
        $display("test override done");
        wr(OFS_FREEZE, 32'h0001_0003);
        wr(OFS_FREEZE, 32'h0000_0003);
        wr(OFS_FREEZE, 32'h0001_0003);
        m_frz = 16'h0003;
        rd(OFS_FREEZE, 32'h0001_0003);
        wr(OFS_MODE, 32'h5555_5555);
        wr(OFS_PULL, 32'h0000_0000);
        wr(OFS_SLEW, 32'hFFFF_FFFF);
        check(slew, 32'hFFFF_FFF0);
        rd(OFS_MODE, m_mode);
        rd(OFS_PULL, m_pull);
        bus(BASES[1], 1'b1, HSIZE_WORD, 32'hFFFF_FFFF);
        bus(BASES[0] + 32'h0000_0040, 1'b1, HSIZE_WORD, 32'hFFFF_FFFF);
        rd(OFS_MODE, m_mode);
        rd(6'h30, ZERO_RST);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        mreset();
        rd(OFS_MODE, MODE_RST_A);
        pads();
        $display("test freeze done");
        final_report();
    end
endmodule
